// ===== pbi_pkg.sv
package pbi_pkg;

   // Bus clock ceiling; nothing in the link logic depends on a lower bound.
   localparam int unsigned PCI_MAX_FREQ_MHZ = 33;

   // Bus commands carried on the command lanes during the address phase.
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;

   // Data-phase clocks a master waits for a claim before giving up.
   localparam logic [2:0] MST_DEVSEL_WAIT = 3'h5;

   // Values after reset.
   localparam logic [31:0] WORD_RST = 32'h0;
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [2:0] CNT_RST = 3'h0;

   typedef enum logic [1:0] {
      PBI_ST_OK,
      PBI_ST_MASTER_ABORT,
      PBI_ST_TARGET_ABORT,
      PBI_ST_RETRY
   } pbi_status_t;

   // Master request: command, address, active-high byte enables, write data.
   typedef struct packed {
      logic [3:0] cmd;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] data;
   } pbi_mst_cmd_t;

   // Access taken as target, handed to the core.
   typedef struct packed {
      logic write;
      logic cfg;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] data;
   } pbi_tgt_acc_t;

   function automatic logic [3:0] pbi_lane_be(input logic [3:0] be, input logic big);
      return big ? {be[0], be[1], be[2], be[3]} : be;
   endfunction

   function automatic logic [31:0] pbi_lane_data(input logic [31:0] d, input logic big);
      return big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
   endfunction

endpackage

// ===== pbi_sync.sv
`timescale 1ns/100ps
module pbi_sync (
   // Clock and reset of the receiving domain
   input wire logic clk,
   input wire logic arst_n,
   // Level from the other domain
   input wire logic d,
   // Level once two stages agree
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic q_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_q <= s3_q;
         end
      end
   end

   assign q = q_q;
endmodule // pbi_sync

// ===== pbi_port.sv
`timescale 1ns/100ps
module pbi_port
   import pbi_pkg::*;
#(
   parameter logic [31:0] BAR_BASE = 32'h0001_0000,
   parameter int BAR_BITS = 8,
   parameter int INT_BITS = 32
) (
   // Core clock, bus clock, reset
   input wire logic clk,
   input wire logic pci_clk,
   input wire logic arst_n,
   // Address/data and command lanes
   input wire logic [31:0] ad_i,
   output logic [31:0] ad_o,
   output logic ad_oe,
   input wire logic [3:0] cbe_n_i,
   output logic [3:0] cbe_n_o,
   output logic cbe_n_oe,
   output logic par_o,
   output logic par_oe,
   // Bus handshakes
   input wire logic frame_n_i,
   output logic frame_n_o,
   output logic frame_n_oe,
   input wire logic irdy_n_i,
   output logic irdy_n_o,
   output logic irdy_n_oe,
   input wire logic trdy_n_i,
   output logic trdy_n_o,
   output logic trdy_n_oe,
   input wire logic stop_n_i,
   output logic stop_n_o,
   output logic stop_n_oe,
   input wire logic devsel_n_i,
   output logic devsel_n_o,
   output logic devsel_n_oe,
   input wire logic idsel_i,
   // Arbitration and interrupt
   input wire logic gnt_n_i,
   output logic req_n_o,
   output logic req_n_oe,
   output logic inta_n_o,
   output logic inta_n_oe,
   // Core side, master requests
   input wire logic big_endian,
   input wire logic mst_valid,
   input wire pbi_mst_cmd_t mst_cmd,
   output logic mst_ready,
   output logic mst_done,
   output logic [31:0] mst_rdata,
   output pbi_status_t mst_status,
   // Core side, target accesses
   output logic tgt_valid,
   output pbi_tgt_acc_t tgt_acc,
   input wire logic tgt_ack,
   input wire logic [31:0] tgt_rdata,
   // Core side, interrupt sources
   input wire logic [INT_BITS-1:0] int_status,
   input wire logic [INT_BITS-1:0] int_mask,
   input wire logic int_enable
);
   typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pbi_mst_state_t;
   typedef enum logic [2:0] {T_IDLE, T_CAPT, T_WAIT, T_DATA, T_TURN} pbi_tgt_state_t;

   // Core domain.
   pbi_mst_cmd_t mst_q;
   logic mst_busy_q;
   logic mst_tgl_q;
   logic mst_done_seen_q;
   logic mst_done_q;
   logic [31:0] mst_rdata_q;
   pbi_status_t mst_status_q;
   logic tgt_seen_q;
   logic tgt_valid_q;
   logic tgt_pend_q;
   logic tgt_ack_tgl_q;
   logic [31:0] tgt_rdata_q;
   pbi_tgt_acc_t tgt_acc_q;
   logic inta_q;
   logic mst_done_s;
   logic tgt_req_s;

   // Bus domain.
   pbi_mst_state_t m_state_q;
   pbi_tgt_state_t t_state_q;
   logic m_req_s;
   logic m_seen_q;
   logic m_done_tgl_q;
   logic [2:0] m_cnt_q;
   logic m_claimed_q;
   logic [31:0] m_rdata_q;
   pbi_status_t m_stat_q;
   logic t_ack_s;
   logic t_ack_seen_q;
   logic t_req_tgl_q;
   pbi_tgt_acc_t t_acc_q;
   logic frame_prev_q;
   logic drive_q;
   logic par_q;
   logic par_oe_q;
   logic addr_phase;
   logic cfg_hit;
   logic mem_hit;

   // Toggles cross between domains; the words they announce stay still until answered.
   pbi_sync u_sync_mst_req (.clk(pci_clk), .arst_n(arst_n), .d(mst_tgl_q), .q(m_req_s));
   pbi_sync u_sync_mst_done (.clk(clk), .arst_n(arst_n), .d(m_done_tgl_q), .q(mst_done_s));
   pbi_sync u_sync_tgt_req (.clk(clk), .arst_n(arst_n), .d(t_req_tgl_q), .q(tgt_req_s));
   pbi_sync u_sync_tgt_ack (.clk(pci_clk), .arst_n(arst_n), .d(tgt_ack_tgl_q), .q(t_ack_s));

   // Core side of master requests; lanes are remapped here so the bus side stays plain.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mst_q <= '0;
         mst_busy_q <= 1'b0;
         mst_tgl_q <= 1'b0;
         mst_done_seen_q <= 1'b0;
         mst_done_q <= 1'b0;
         mst_rdata_q <= WORD_RST;
         mst_status_q <= PBI_ST_OK;
      end else begin
         mst_done_seen_q <= mst_done_s;
         mst_done_q <= mst_done_s != mst_done_seen_q;
         if (mst_done_s != mst_done_seen_q) begin
            mst_busy_q <= 1'b0;
            mst_rdata_q <= pbi_lane_data(m_rdata_q, big_endian);
            mst_status_q <= m_stat_q;
         end else if (mst_valid && !mst_busy_q) begin
            mst_q.cmd <= mst_cmd.cmd;
            mst_q.addr <= mst_cmd.addr;
            mst_q.be <= pbi_lane_be(mst_cmd.be, big_endian);
            mst_q.data <= pbi_lane_data(mst_cmd.data, big_endian);
            mst_busy_q <= 1'b1;
            mst_tgl_q <= ~mst_tgl_q;
         end
      end
   end

   assign mst_ready = !mst_busy_q;
   assign mst_done = mst_done_q;
   assign mst_rdata = mst_rdata_q;
   assign mst_status = mst_status_q;

   // Core side of target accesses.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tgt_seen_q <= 1'b0;
         tgt_valid_q <= 1'b0;
         tgt_pend_q <= 1'b0;
         tgt_ack_tgl_q <= 1'b0;
         tgt_rdata_q <= WORD_RST;
         tgt_acc_q <= '0;
      end else begin
         tgt_seen_q <= tgt_req_s;
         tgt_valid_q <= tgt_req_s != tgt_seen_q;
         if (tgt_ack && tgt_pend_q) begin
            tgt_pend_q <= 1'b0;
            tgt_rdata_q <= pbi_lane_data(tgt_rdata, big_endian);
            tgt_ack_tgl_q <= ~tgt_ack_tgl_q;
         end
         if (tgt_req_s != tgt_seen_q) begin
            tgt_pend_q <= 1'b1;
            tgt_acc_q.write <= t_acc_q.write;
            tgt_acc_q.cfg <= t_acc_q.cfg;
            tgt_acc_q.addr <= t_acc_q.addr;
            tgt_acc_q.be <= pbi_lane_be(t_acc_q.be, big_endian);
            tgt_acc_q.data <= pbi_lane_data(t_acc_q.data, big_endian);
         end
      end
   end

   assign tgt_valid = tgt_valid_q;
   assign tgt_acc = tgt_acc_q;

   // Open-drain interrupt; only ever pulled low.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inta_q <= 1'b0;
      end else begin
         inta_q <= (|(int_status & int_mask)) && int_enable;
      end
   end

   assign inta_n_o = 1'b0;
   assign inta_n_oe = inta_q;

   // Master sequencer. Single-word transfers keep the claim timeout simple.
   always_ff @(posedge pci_clk or negedge arst_n) begin
      if (!arst_n) begin
         m_state_q <= M_IDLE;
         m_seen_q <= 1'b0;
         m_done_tgl_q <= 1'b0;
         m_cnt_q <= CNT_RST;
         m_claimed_q <= 1'b0;
         m_rdata_q <= WORD_RST;
         m_stat_q <= PBI_ST_OK;
      end else begin
         m_seen_q <= m_req_s;
         unique case (m_state_q)
            M_IDLE: begin
               if (m_req_s != m_seen_q) begin
                  m_state_q <= M_REQ;
               end
            end
            M_REQ: begin
               if (!gnt_n_i && frame_n_i && irdy_n_i && t_state_q == T_IDLE) begin
                  m_state_q <= M_ADDR;
               end
            end
            M_ADDR: begin
               m_cnt_q <= CNT_RST;
               m_claimed_q <= 1'b0;
               m_state_q <= M_DATA;
            end
            M_DATA: begin
               m_cnt_q <= m_cnt_q + 3'h1;
               if (!devsel_n_i) begin
                  m_claimed_q <= 1'b1;
               end
               if (!devsel_n_i && !trdy_n_i) begin
                  m_rdata_q <= ad_i;
                  m_stat_q <= PBI_ST_OK;
                  m_state_q <= M_TURN;
               end else if (!stop_n_i) begin
                  m_stat_q <= devsel_n_i ? PBI_ST_TARGET_ABORT : PBI_ST_RETRY;
                  m_state_q <= M_TURN;
               end else if (devsel_n_i && !m_claimed_q && m_cnt_q == MST_DEVSEL_WAIT) begin
                  m_stat_q <= PBI_ST_MASTER_ABORT;
                  m_state_q <= M_TURN;
               end
            end
            M_TURN: begin
               m_done_tgl_q <= ~m_done_tgl_q;
               m_state_q <= M_IDLE;
            end
         endcase
      end
   end

   // Target decode on the first edge with frame newly low.
   assign addr_phase = !frame_n_i && frame_prev_q;
   assign cfg_hit = idsel_i && ad_i[1:0] == 2'b00
                    && (cbe_n_i == CMD_CFG_RD || cbe_n_i == CMD_CFG_WR);
   assign mem_hit = ad_i[31:BAR_BITS] == BAR_BASE[31:BAR_BITS]
                    && (cbe_n_i == CMD_MEM_RD || cbe_n_i == CMD_MEM_WR);

   always_ff @(posedge pci_clk or negedge arst_n) begin
      if (!arst_n) begin
         t_state_q <= T_IDLE;
         t_ack_seen_q <= 1'b0;
         t_req_tgl_q <= 1'b0;
         t_acc_q <= '0;
         frame_prev_q <= 1'b1;
      end else begin
         frame_prev_q <= frame_n_i;
         t_ack_seen_q <= t_ack_s;
         unique case (t_state_q)
            T_IDLE: begin
               if (addr_phase && (cfg_hit || mem_hit)
                   && (m_state_q == M_IDLE || m_state_q == M_REQ)) begin
                  t_acc_q.addr <= ad_i;
                  t_acc_q.write <= cbe_n_i[0];
                  t_acc_q.cfg <= cfg_hit;
                  t_state_q <= T_CAPT;
               end
            end
            T_CAPT: begin
               if (!irdy_n_i) begin
                  t_acc_q.be <= ~cbe_n_i;
                  t_acc_q.data <= ad_i;
                  t_req_tgl_q <= ~t_req_tgl_q;
                  t_state_q <= T_WAIT;
               end
            end
            T_WAIT: begin
               if (t_ack_s != t_ack_seen_q) begin
                  t_state_q <= T_DATA;
               end
            end
            T_DATA: begin
               t_state_q <= T_TURN;
            end
            T_TURN: begin
               t_state_q <= T_IDLE;
            end
         endcase
      end
   end

   // Pin drive decoded from the two sequencers. Idle bus lines float.
   always_comb begin
      ad_o = WORD_RST;
      ad_oe = 1'b0;
      cbe_n_o = NIB_RST;
      cbe_n_oe = 1'b0;
      frame_n_o = 1'b1;
      frame_n_oe = 1'b0;
      irdy_n_o = 1'b1;
      irdy_n_oe = 1'b0;
      trdy_n_o = 1'b1;
      trdy_n_oe = 1'b0;
      stop_n_o = 1'b1;
      stop_n_oe = 1'b0;
      devsel_n_o = 1'b1;
      devsel_n_oe = 1'b0;
      unique case (m_state_q)
         M_ADDR: begin
            ad_o = mst_q.addr;
            ad_oe = 1'b1;
            cbe_n_o = mst_q.cmd;
            cbe_n_oe = 1'b1;
            frame_n_o = 1'b0;
            frame_n_oe = 1'b1;
            irdy_n_oe = 1'b1;
         end
         M_DATA: begin
            ad_o = mst_q.data;
            ad_oe = mst_q.cmd[0];
            cbe_n_o = ~mst_q.be;
            cbe_n_oe = 1'b1;
            frame_n_oe = 1'b1;
            irdy_n_o = 1'b0;
            irdy_n_oe = 1'b1;
         end
         M_TURN: begin
            irdy_n_oe = 1'b1;
         end
         default: begin
         end
      endcase
      unique case (t_state_q)
         T_CAPT, T_WAIT: begin
            devsel_n_o = 1'b0;
            devsel_n_oe = 1'b1;
            trdy_n_oe = 1'b1;
            stop_n_oe = 1'b1;
            ad_o = tgt_rdata_q;
            ad_oe = t_state_q == T_WAIT && !t_acc_q.write;
         end
         T_DATA: begin
            devsel_n_o = 1'b0;
            devsel_n_oe = 1'b1;
            trdy_n_o = 1'b0;
            trdy_n_oe = 1'b1;
            stop_n_o = frame_n_i;
            stop_n_oe = 1'b1;
            ad_o = tgt_rdata_q;
            ad_oe = !t_acc_q.write;
         end
         T_TURN: begin
            devsel_n_oe = 1'b1;
            trdy_n_oe = 1'b1;
            stop_n_oe = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Parity trails the lanes it covers by one clock, and only for phases this end drove.
   always_ff @(posedge pci_clk or negedge arst_n) begin
      if (!arst_n) begin
         par_q <= 1'b0;
         par_oe_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         par_q <= ^{ad_o, cbe_n_i};
         par_oe_q <= ad_oe;
         drive_q <= 1'b1;
      end
   end

   assign par_o = par_q;
   assign par_oe = par_oe_q;
   assign req_n_o = m_state_q != M_REQ;
   assign req_n_oe = drive_q;

endmodule // pbi_port

// ===== pbi_port_sva.sv
`timescale 1ns/100ps
module pbi_port_sva
   import pbi_pkg::*;
#(
   parameter logic [31:0] BAR_BASE = 32'h0001_0000,
   parameter int BAR_BITS = 8,
   parameter int INT_BITS = 32
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic pci_clk,
   input wire logic arst_n,
   // Lanes
   input wire logic [31:0] ad_i,
   input wire logic [31:0] ad_o,
   input wire logic ad_oe,
   input wire logic [3:0] cbe_n_i,
   input wire logic [3:0] cbe_n_o,
   input wire logic cbe_n_oe,
   input wire logic par_o,
   input wire logic par_oe,
   // Handshakes
   input wire logic frame_n_i,
   input wire logic frame_n_o,
   input wire logic frame_n_oe,
   input wire logic irdy_n_o,
   input wire logic irdy_n_oe,
   input wire logic trdy_n_o,
   input wire logic trdy_n_oe,
   input wire logic stop_n_oe,
   input wire logic devsel_n_o,
   input wire logic devsel_n_oe,
   input wire logic idsel_i,
   // Arbitration and interrupt
   input wire logic gnt_n_i,
   input wire logic req_n_o,
   input wire logic req_n_oe,
   input wire logic inta_n_o,
   input wire logic inta_n_oe,
   input wire logic [INT_BITS-1:0] int_status,
   input wire logic [INT_BITS-1:0] int_mask,
   input wire logic int_enable
);
   default clocking cb @(posedge pci_clk); endclocking
   default disable iff (!arst_n);

   function automatic logic own_hit(logic [31:0] a, logic [3:0] c, logic s);
      return (s && a[1:0] == 2'h0 && c[3:1] == 3'h5) ||
         ((a >> BAR_BITS) == (BAR_BASE >> BAR_BITS) && c[3:1] == 3'h3);
   endfunction

   sequence addr_ph;
      !frame_n_o && frame_n_oe && ad_oe && cbe_n_oe;
   endsequence
   sequence data_ph;
      frame_n_o && frame_n_oe && !irdy_n_o && irdy_n_oe;
   endsequence

   a_master_phases: assert property ($rose(frame_n_oe) |-> addr_ph ##1 data_ph)
      else $error("master phase order wrong");
   a_master_grant: assert property ($rose(frame_n_oe) |-> $past(!gnt_n_i) && $past(!req_n_o))
      else $error("master started without grant or request");
   a_claim_own: assert property ($rose(devsel_n_oe) |-> !devsel_n_o && $past(!frame_n_i) &&
      $past(frame_n_i, 2) && own_hit($past(ad_i), $past(cbe_n_i), $past(idsel_i)))
      else $error("claim without own address");
   a_trdy_pulse: assert property (trdy_n_oe && !trdy_n_o |-> !devsel_n_o ##1 (trdy_n_o || !trdy_n_oe))
      else $error("target ready not a single claimed clock");
   a_par_even: assert property (par_oe |-> (^{$past(ad_i), $past(cbe_n_i), par_o}) == 1'b0)
      else $error("parity not even");
   a_par_timing: assert property (1'b1 |-> par_oe == $past(ad_oe))
      else $error("parity drive not one clock after lanes");
   a_inta_level: assert property (@(posedge clk) 1'b1 |=>
      inta_n_oe == $past(|(int_status & int_mask) && int_enable) && !(inta_n_oe && inta_n_o))
      else $error("interrupt pin does not follow condition");
   a_reset_float: assert property (@(posedge clk) disable iff (1'b0) !arst_n |->
      !(ad_oe | cbe_n_oe | par_oe | frame_n_oe | irdy_n_oe | trdy_n_oe | devsel_n_oe |
      stop_n_oe | req_n_oe | inta_n_oe))
      else $error("pin driven during reset");
endmodule // pbi_port_sva

bind pbi_port pbi_port_sva #(.BAR_BASE(BAR_BASE), .BAR_BITS(BAR_BITS), .INT_BITS(INT_BITS)) sva_u (
   .clk, .pci_clk, .arst_n, .ad_i, .ad_o, .ad_oe, .cbe_n_i, .cbe_n_o, .cbe_n_oe, .par_o,
   .par_oe, .frame_n_i, .frame_n_o, .frame_n_oe, .irdy_n_o, .irdy_n_oe, .trdy_n_o, .trdy_n_oe,
   .stop_n_oe, .devsel_n_o, .devsel_n_oe, .idsel_i, .gnt_n_i, .req_n_o, .req_n_oe, .inta_n_o,
   .inta_n_oe, .int_status, .int_mask, .int_enable);

// ===== pbi_far_end.sv
`timescale 1ns/100ps
module pbi_far_end #(
   parameter logic [31:0] RD_WORD = 32'hc3a5_0f96
) (
   // Bus clock and reset
   input wire logic pci_clk,
   input wire logic arst_n,
   // Wires as resolved
   input wire logic req_n,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic [31:0] ad,
   input wire logic [3:0] cbe_n,
   input wire logic claim,
   // Drives of arbiter and target
   output logic gnt_n,
   output logic devsel_n,
   output logic trdy_n,
   output logic t_oe,
   output logic [31:0] ad_o,
   output logic ad_oe,
   // Last transfer seen
   output logic [31:0] seen_addr,
   output logic [3:0] seen_cmd,
   output logic [31:0] seen_data,
   output logic [3:0] seen_be_n
);
   logic [1:0] st_q;
   logic frame_d1_q;
   // A lone arbiter: grant follows request one clock later.
   always_ff @(posedge pci_clk or negedge arst_n) begin
      if (!arst_n) gnt_n <= 1'b1;
      else gnt_n <= req_n;
   end
   // Target claims a clock after the address, then is ready once; the word moves
   // only at the edge where the master's ready is low as well.
   always_ff @(posedge pci_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= 2'h0;
         frame_d1_q <= 1'b1;
         seen_addr <= 32'h0;
         seen_cmd <= 4'h0;
         seen_data <= 32'h0;
         seen_be_n <= 4'h0;
      end else begin
         frame_d1_q <= frame_n;
         case (st_q)
            2'h0: if (!frame_n && frame_d1_q && claim) begin
               st_q <= 2'h1;
               seen_addr <= ad;
               seen_cmd <= cbe_n;
            end
            2'h1: st_q <= 2'h2;
            2'h2: if (!irdy_n) begin
               st_q <= 2'h3;
               seen_data <= ad;
               seen_be_n <= cbe_n;
            end
            default: st_q <= 2'h0;
         endcase
      end
   end
   assign devsel_n = !(st_q == 2'h1 || st_q == 2'h2);
   assign trdy_n = st_q != 2'h2;
   assign t_oe = st_q != 2'h0;
   assign ad_oe = st_q == 2'h2 && !seen_cmd[0];
   assign ad_o = RD_WORD;
endmodule // pbi_far_end

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
   import pbi_pkg::*;
   localparam logic [31:0] RD_WORD = 32'hc3a5_0f96;
   localparam logic [31:0] CORE_WORD = 32'h1122_3344;
   localparam logic [31:0] TB_WORD = 32'h6b7c_8d9e;
   localparam logic [31:0] BAR = 32'h0001_0000;
   logic clk, pci_clk, arst_n, idsel, claim, big_endian, mst_valid, tgt_ack, int_enable;
   logic tb_frame_n, tb_irdy_n, tb_ad_oe, mst_ready, mst_done, tgt_valid;
   logic [3:0] tb_cbe_n, cbe_w, cbe_n_o, seen_cmd, seen_be_n;
   logic [31:0] tb_ad, ad_w, ad_o, p_ad, mst_rdata, tgt_rdata, seen_addr, seen_data;
   logic [31:0] int_status, int_mask;
   logic ad_oe, cbe_n_oe, frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, trdy_n_o, trdy_n_oe;
   logic stop_n_o, stop_n_oe, devsel_n_o, devsel_n_oe, req_n_o, req_n_oe, inta_n_o, inta_n_oe;
   logic par_o, par_oe, tb_stop_n;
   logic frame_w, irdy_w, trdy_w, stop_w, devsel_w, req_w, gnt_w, p_devsel, p_trdy, p_oe, p_ad_oe;
   pbi_mst_cmd_t mst_cmd;
   pbi_status_t mst_status;
   pbi_tgt_acc_t tgt_acc, acc_q;
   int err_total = 0;
   int comparisons = 0;

   // Released lines without a pull-up show a pattern that changes, never the last value.
   assign ad_w = ad_oe ? ad_o : p_ad_oe ? p_ad : tb_ad_oe ? tb_ad : 32'h5a5a_a5a5 ^ {32{pci_clk}};
   assign cbe_w = cbe_n_oe ? cbe_n_o : tb_cbe_n;
   assign frame_w = frame_n_oe ? frame_n_o : tb_frame_n;
   assign irdy_w = irdy_n_oe ? irdy_n_o : tb_irdy_n;
   assign trdy_w = trdy_n_oe ? trdy_n_o : p_oe ? p_trdy : 1'b1;
   assign devsel_w = devsel_n_oe ? devsel_n_o : p_oe ? p_devsel : 1'b1;
   assign stop_w = stop_n_oe ? stop_n_o : tb_stop_n;
   assign req_w = req_n_oe ? req_n_o : 1'b1;

   pbi_port dut_u (.clk, .pci_clk, .arst_n, .ad_i(ad_w), .ad_o, .ad_oe, .cbe_n_i(cbe_w), .cbe_n_o,
      .cbe_n_oe, .par_o, .par_oe, .frame_n_i(frame_w), .frame_n_o, .frame_n_oe,
      .irdy_n_i(irdy_w), .irdy_n_o, .irdy_n_oe, .trdy_n_i(trdy_w), .trdy_n_o, .trdy_n_oe,
      .stop_n_i(stop_w), .stop_n_o, .stop_n_oe, .devsel_n_i(devsel_w), .devsel_n_o, .devsel_n_oe,
      .idsel_i(idsel), .gnt_n_i(gnt_w), .req_n_o, .req_n_oe, .inta_n_o, .inta_n_oe, .big_endian,
      .mst_valid, .mst_cmd, .mst_ready, .mst_done, .mst_rdata, .mst_status, .tgt_valid, .tgt_acc,
      .tgt_ack, .tgt_rdata, .int_status, .int_mask, .int_enable);
   pbi_far_end far_u (.pci_clk, .arst_n, .req_n(req_w), .frame_n(frame_w), .irdy_n(irdy_w),
      .ad(ad_w), .cbe_n(cbe_w), .claim, .gnt_n(gnt_w), .devsel_n(p_devsel), .trdy_n(p_trdy),
      .t_oe(p_oe), .ad_o(p_ad), .ad_oe(p_ad_oe), .seen_addr, .seen_cmd, .seen_data, .seen_be_n);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      pci_clk = 1'b0;
      #3.7;
      forever #7.5 pci_clk = ~pci_clk;
   end
   // Core answers each target access on the next clock.
   always @(posedge clk) begin
      tgt_ack <= #1 tgt_valid;
      if (tgt_valid) acc_q <= tgt_acc;
   end

   task automatic results();
      if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (exp !== got) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic do_reset();
      arst_n = 1'b0;
      repeat (16) @(posedge clk);
      chk("float", 32'h0, {ad_oe, cbe_n_oe, frame_n_oe, irdy_n_oe, trdy_n_oe, req_n_oe,
         devsel_n_oe, stop_n_oe, par_oe, inta_n_oe});
      #1 arst_n = 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic mst_xfer(input logic [3:0] cmd, input logic big, input logic cl);
      int n;
      @(posedge clk);
      #1 claim = cl;
      big_endian = big;
      mst_cmd = '{cmd, 32'h8000_0040, 4'h3, 32'ha1b2_c3d4};
      chk("ready", 32'h1, mst_ready);
      mst_valid = 1'b1;
      @(posedge clk);
      #1 mst_valid = 1'b0;
      for (n = 0; n < 600 && mst_done !== 1'b1; n++) @(posedge clk) #1;
      if (n == 600) begin
         err_total++;
         results();
      end
   endtask
   task automatic t_master();
      for (int i = 0; i < 4; i++) begin
         mst_xfer(i[1] ? CMD_MEM_RD : CMD_MEM_WR, i[0], 1'b1);
         chk("status", PBI_ST_OK, mst_status);
         chk("addr", 32'h8000_0040, seen_addr);
         chk("cmd", i[1] ? CMD_MEM_RD : CMD_MEM_WR, seen_cmd);
         chk("lanes", i[0] ? 4'h3 : 4'hc, seen_be_n);
         if (i[1]) chk("rdata", i[0] ? 32'h960f_a5c3 : RD_WORD, mst_rdata);
         else chk("wdata", i[0] ? 32'hd4c3_b2a1 : 32'ha1b2_c3d4, seen_data);
      end
      mst_xfer(CMD_MEM_WR, 1'b0, 1'b0);
      chk("abort", PBI_ST_MASTER_ABORT, mst_status);
      tb_stop_n = 1'b0;
      mst_xfer(CMD_MEM_RD, 1'b0, 1'b0);
      tb_stop_n = 1'b1;
      chk("target abort", PBI_ST_TARGET_ABORT, mst_status);
   endtask
   task automatic tgt_cyc(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
      input logic exp_hit);
      int n;
      logic hit;
      logic par_exp;
      hit = 1'b0;
      par_exp = 1'b0;
      @(posedge pci_clk);
      #1 tb_frame_n = 1'b0;
      tb_ad_oe = 1'b1;
      tb_ad = addr;
      tb_cbe_n = cmd;
      idsel = sel;
      @(posedge pci_clk);
      #1 tb_frame_n = 1'b1;
      tb_irdy_n = 1'b0;
      tb_cbe_n = 4'h0;
      tb_ad = TB_WORD;
      tb_ad_oe = cmd[0];
      idsel = 1'b0;
      for (n = 0; n < 80; n++) begin
         @(posedge pci_clk);
         #1 if (devsel_w === 1'b0) hit = 1'b1;
         if (trdy_w === 1'b0 || (!hit && n == 4)) break;
      end
      chk("claim", exp_hit, hit);
      if (hit && trdy_w !== 1'b0) begin
         err_total++;
         results();
      end
      if (hit) chk("stop", 32'h1, stop_w);
      if (hit && !cmd[0]) chk("tgt rdata", CORE_WORD, ad_w);
      par_exp = ^{ad_w, cbe_w};
      @(posedge pci_clk);
      #1 tb_irdy_n = 1'b1;
      tb_ad_oe = 1'b0;
      tb_cbe_n = 4'hf;
      if (hit && !cmd[0]) begin
         chk("tgt par", {30'h0, 1'b1, par_exp}, {30'h0, par_oe, par_o});
      end
      repeat (3) @(posedge clk);
      if (hit) begin
         chk("acc addr", addr, acc_q.addr);
         chk("acc kind", {26'h0, cmd[0], !cmd[2], 4'hf},
            {26'h0, acc_q.write, acc_q.cfg, acc_q.be});
         if (cmd[0]) chk("acc data", TB_WORD, acc_q.data);
      end
   endtask
   task automatic t_target();
      tgt_cyc(CMD_MEM_WR, BAR + 32'h8, 1'b0, 1'b1);
      tgt_cyc(CMD_MEM_RD, BAR + 32'hfc, 1'b0, 1'b1);
      tgt_cyc(CMD_MEM_WR, BAR + 32'h100, 1'b0, 1'b0);
      tgt_cyc(CMD_CFG_WR, 32'h0000_0010, 1'b1, 1'b1);
      tgt_cyc(CMD_CFG_RD, 32'h0000_0010, 1'b0, 1'b0);
      tgt_cyc(CMD_CFG_RD, 32'h0000_0014, 1'b1, 1'b1);
   endtask
   task automatic t_irq();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         #1 int_status = 32'h0000_0100;
         int_mask = i[0] ? 32'h0000_0100 : 32'h0000_0001;
         int_enable = i[1];
         repeat (2) @(posedge clk);
         #1 chk("inta", {31'h0, i == 3}, inta_n_oe);
         if (i == 3) chk("inta low", 32'h0, inta_n_o);
      end
      int_enable = 1'b0;
   endtask

   initial begin
      {idsel, claim, big_endian, mst_valid, int_enable, tb_ad_oe} = '0;
      {tb_frame_n, tb_irdy_n, tb_stop_n, tb_cbe_n} = '1;
      {tb_ad, int_status, int_mask, mst_cmd} = '0;
      tgt_rdata = CORE_WORD;
      do_reset();
      t_master();
      t_target();
      t_irq();
      do_reset();
      t_master();
      results();
   end
endmodule // testbench
